// >>> rtl/commit_page_por_pkg.sv
`default_nettype none
package commit_page_por_pkg;
  typedef logic [3:0] page_t;
  typedef enum {PorIdle, PorWait, PorDone} por_state_t;
endpackage : commit_page_por_pkg
`default_nettype wire

// >>> rtl/commit_page_por_regs.svh
`ifndef COMMIT_PAGE_POR_REGS_SVH
`define COMMIT_PAGE_POR_REGS_SVH
`define ADDR_COMMIT_PAGE_SELECT     8'h91
`define ADDR_POWERON_RAMP_CONTROL   8'had
`define ADDR_CRYSTAL_LOAD_CAP_HIGH  8'hc7
`define ADDR_CRYSTAL_LOAD_CAP_LOW   8'hc8
`define COMMIT_PAGE_RESET           4'h0
`define COMMIT_PAGE_LAST            4'h5
`define FIRST_SLOW_BIT              2
`define SECOND_SLOW_BIT             6
`define FIRST_SLOW_RESET            1'b0
`define SECOND_SLOW_RESET           1'b0
`define PAGE_COUNT                  6
`define SLOW_DELAY_MS               60
`define CLK_HZ                      25000000
`define SLOW_DELAY_CYCLES           ((`SLOW_DELAY_MS * `CLK_HZ) / 1000)
`endif

// >>> rtl/commit_page_por_xo_readback_regs.sv
// Operation
// - page field selects commit target region
// - six pages; two select pins pick power-up page 0 to 3
// - slow bits at 2 and 6 slow ramp
// - either slow bit plus both loop bandwidths adds 60 ms delay
// - ten-bit capacitance code read-only, split bytes
`include "commit_page_por_regs.svh"
`default_nettype none
module commit_page_por_xo_readback_regs
  import commit_page_por_pkg::*;
#(
  parameter int unsigned SLOW_DELAY_CYCLES = `SLOW_DELAY_CYCLES
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // register port
  input  wire logic       regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // nonvolatile restore of the first slow bit, taken at reset release
  input  wire logic       firstSlowNvm,
  // page-select pins and pll state
  input  wire logic [1:0] pageSelPins,
  input  wire logic       firstPllLoopBandwidth,
  input  wire logic       secondPllLoopBandwidth,
  input  wire logic [9:0] crystalLoadCapCode,
  input  wire logic       poweronStart,
  // outputs to the store operation and power-on sequencer
  output logic      [3:0] commitPageField,
  output logic      [2:0] powerupPage,
  output logic            firstPllSlowPoweron,
  output logic            secondPllSlowPoweron,
  output logic            poweronDone
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  page_t       pageReg;
  page_t       pageNext;
  logic        slow1Reg;
  logic        slow1Next;
  logic        slow2Reg;
  logic        slow2Next;
  logic        nvmLoadReg;
  logic [9:0]  capReg;
  logic [2:0]  pinPageReg;
  por_state_t  porReg;
  por_state_t  porNext;
  logic [21:0] cntReg;
  logic [21:0] cntNext;

  // write strobes, one per writable register
  wire logic wrPage;
  wire logic wrPor;
  assign wrPage = regWrite && hit(regAddr, `ADDR_COMMIT_PAGE_SELECT);
  assign wrPor  = regWrite && hit(regAddr, `ADDR_POWERON_RAMP_CONTROL);

  // read selects
  wire logic rdPage;
  wire logic rdPor;
  wire logic rdCapHigh;
  wire logic rdCapLow;
  assign rdPage    = hit(regAddr, `ADDR_COMMIT_PAGE_SELECT);
  assign rdPor     = hit(regAddr, `ADDR_POWERON_RAMP_CONTROL);
  assign rdCapHigh = hit(regAddr, `ADDR_CRYSTAL_LOAD_CAP_HIGH);
  assign rdCapLow  = hit(regAddr, `ADDR_CRYSTAL_LOAD_CAP_LOW);

  // register views with reserved positions forced to zero
  wire logic [7:0] pageView;
  wire logic [7:0] porView;
  wire logic [7:0] capHighView;
  wire logic [7:0] capLowView;
  assign pageView    = {4'h0, pageReg};
  assign porView     = {1'b0, slow2Reg, 3'h0, slow1Reg, 2'h0};
  assign capHighView = {6'h00, capReg[9:8]};
  assign capLowView  = capReg[7:0];

  assign regRdata = rdPage    ? pageView :
                    rdPor     ? porView :
                    rdCapHigh ? capHighView :
                    rdCapLow  ? capLowView :
                    8'h00;

  // the restored value wins over a write in the load cycle
  assign slow1Next = nvmLoadReg ? firstSlowNvm :
                     (wrPor ? regWdata[`FIRST_SLOW_BIT] : slow1Reg);
  assign slow2Next = wrPor ? regWdata[`SECOND_SLOW_BIT] : slow2Reg;
  assign pageNext  = wrPage ? regWdata[3:0] : pageReg;

  wire logic slowActive;
  wire logic cntEnd;
  assign slowActive = (slow1Reg || slow2Reg) && firstPllLoopBandwidth
                      && secondPllLoopBandwidth;
  assign cntEnd     = (cntReg == 22'(SLOW_DELAY_CYCLES - 1));
  assign cntNext    = (porReg == PorWait) ? cntReg + 22'h000001 : 22'h000000;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pageReg <= `COMMIT_PAGE_RESET;
    end
    else
    begin
      pageReg <= pageNext;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slow1Reg <= `FIRST_SLOW_RESET;
    end
    else
    begin
      slow1Reg <= slow1Next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      slow2Reg <= `SECOND_SLOW_RESET;
    end
    else
    begin
      slow2Reg <= slow2Next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nvmLoadReg <= 1'b1;
    end
    else
    begin
      nvmLoadReg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      capReg <= 10'h000;
    end
    else
    begin
      capReg <= crystalLoadCapCode;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pinPageReg <= 3'h0;
    end
    else
    begin
      pinPageReg <= {1'b0, pageSelPins};
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      porReg <= PorIdle;
    end
    else
    begin
      porReg <= porNext;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cntReg <= 22'h000000;
    end
    else
    begin
      cntReg <= cntNext;
    end
  end

  always_comb
  begin
    porNext = porReg;
    case (porReg)
      PorIdle:
      begin
        if (poweronStart)
        begin
          if (slowActive)
            porNext = PorWait;
          else
            porNext = PorDone;
        end
      end
      PorWait:
      begin
        if (cntEnd)
          porNext = PorDone;
      end
      PorDone:
      begin
        porNext = PorDone;
      end
      default:
      begin
        porNext = PorIdle;
      end
    endcase
  end

  assign commitPageField      = pageReg;
  assign powerupPage          = pinPageReg;
  assign firstPllSlowPoweron  = slow1Reg;
  assign secondPllSlowPoweron = slow2Reg;
  assign poweronDone          = (porReg == PorDone);
endmodule : commit_page_por_xo_readback_regs
`default_nettype wire

// >>> test/host_model.sv
`default_nettype none
module host_model (input wire logic clk, output logic we, output logic [7:0] a, d);
  timeunit 1ns;
  timeprecision 1ns;
  initial {we, a, d} = 17'h00000;
  // request held over one sampling edge, read data settled by the falling edge
  task acc(input logic [7:0] ad, dd, input logic w);
    @(posedge clk);
    we <= w;
    a <= ad;
    d <= dd;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
  endtask : acc
endmodule : host_model
`default_nettype wire

// >>> test/regs_checker.sv
`default_nettype none
module regs_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       regWrite,
  input wire logic       firstPllSlowPoweron,
  input wire logic       secondPllSlowPoweron,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [9:0] crystalLoadCapCode,
  input wire logic [3:0] commitPageField
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic       wPg  = regWrite && regAddr == 8'h91;
  wire logic       wPor = regWrite && regAddr == 8'had;
  wire logic [1:0] slow = {secondPllSlowPoweron, firstPllSlowPoweron};
  AST_PG: assert property (wPg |=> commitPageField == $past(regWdata[3:0]))
    else $error("page field not taken from write");
  AST_PGHOLD: assert property (!wPg |=> $stable(commitPageField))
    else $error("page field moved without write");
  AST_SLOW: assert property (wPor && !$past(srst) |=>
    slow == {$past(regWdata[6]), $past(regWdata[2])}) else $error("slow bits wrong");
  AST_RDPOR: assert property (regAddr == 8'had |->
    regRdata == {1'b0, slow[1], 3'h0, slow[0], 2'h0}) else $error("por read wrong");
  AST_CAPH: assert property (regAddr == 8'hc7 && !$past(srst) |->
    regRdata == {6'h00, $past(crystalLoadCapCode[9:8])}) else $error("cap high wrong");
  AST_CAPL: assert property (regAddr == 8'hc8 && !$past(srst) |->
    regRdata == $past(crystalLoadCapCode[7:0])) else $error("cap low wrong");
  cover property (wPg ##1 regAddr == 8'h91);
  cover property (regWrite && regAddr == 8'had);
  cover property (regAddr == 8'hc7 && regRdata != 8'h00);
endmodule : regs_checker
bind commit_page_por_xo_readback_regs regs_checker u_regs_checker (.*);
`default_nettype wire

// >>> test/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, nvm = 0, b1 = 0, b2 = 0, st = 0, we, pd, s1, s2;
  logic [7:0] a, d, q;
  logic [1:0] pins = 0;
  logic [9:0] cap = 0;
  logic [7:0] rstAddr [4] = '{8'h91, 8'had, 8'hc7, 8'hc8};
  logic [3:0] pg;
  logic [2:0] pu;
  int mismatches = 0, check_count = 0, i;
  initial forever #20 clk = ~clk;
  host_model u_host_model (.clk, .we, .a, .d);
  commit_page_por_xo_readback_regs #(.SLOW_DELAY_CYCLES(20)) u_commit_page_por_xo_readback_regs (
    .clk, .srst, .regWrite(we), .regAddr(a), .regWdata(d), .regRdata(q), .firstSlowNvm(nvm),
    .pageSelPins(pins), .firstPllLoopBandwidth(b1), .secondPllLoopBandwidth(b2),
    .crystalLoadCapCode(cap), .poweronStart(st), .commitPageField(pg), .powerupPage(pu),
    .firstPllSlowPoweron(s1), .secondPllSlowPoweron(s2), .poweronDone(pd));
  task chk(string n, logic [9:0] s, e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task rw(string n, logic [7:0] ad, dd, logic w, logic [7:0] e);
    u_host_model.acc(ad, dd, w);
    chk(n, q, e);
  endtask : rw
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task t_reset;
    foreach (rstAddr[j]) rw("rst", rstAddr[j], 8'h00, 1'b0, 8'h00);
    chk("pdidle", 10'(pd), 0);
  endtask : t_reset
  task t_page;
    for (i = 0; i < 6; i++) rw("page", 8'h91, 8'(i) | 8'hf0, 1, 8'(i));
    chk("pgport", pg, 5);
  endtask : t_page
  task t_ro;
    @(posedge clk) {cap, b1, b2} <= {10'h2a5, 2'b11};
    rw("por", 8'had, 8'hff, 1, 8'h44);
    chk("slow", {s2, s1}, 3);
    rw("caph", 8'hc7, 8'hff, 1, 8'h02);
    rw("capl", 8'hc8, 8'h00, 1, 8'ha5);
    rw("none", 8'h20, 8'hff, 1, 8'h00);
  endtask : t_ro
  task t_pins;
    @(posedge clk) pins <= 2'h3;
    repeat (2) @(posedge clk);
    @(negedge clk) chk("pupage", pu, 3);
  endtask : t_pins
  task t_delay;
    @(posedge clk) st <= 1'b1;
    for (i = 0; i < 40 && pd !== 1'b1; i++) @(negedge clk);
    chk("delay", 10'(i >= 19 && i <= 23), 1);
    if (pd !== 1'b1) report_and_stop;
  endtask : t_delay
  // mid-run reset clears the slow bits, so the start finishes at once
  task t_fast;
    @(posedge clk) {srst, st} <= 2'b10;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk) chk("pdreset", 10'(pd), 0);
    @(posedge clk) st <= 1'b1;
    repeat (2) @(negedge clk);
    chk("fast", 10'(pd), 1);
  endtask : t_fast
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 0;
    t_reset;
    t_page;
    t_ro;
    t_pins;
    t_delay;
    t_fast;
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
